// ---- hdl/amtc_top.sv ----
// AXI4-Lite control block: two result monitors, hardware start selection, soft reset
`timescale 1ns/1ps
`default_nettype none
`include "amtc_params.svh"
// Summary of operation
// - Monitor 0 compares and interrupts only while its enable bit is set.
// - Monitor 0 fires on result below compare value at direction 0, above it at direction 1.
// - Monitor 0 select codes 0000-0111 watch normal results 0-7, 1xxx the priority result.
// - Monitor 1 compares and interrupts only while its enable bit is set.
// - Monitor 1 fires on result below compare value at direction 0, above it at direction 1.
// - Monitor 1 select codes 0000-0111 watch normal results 0-7, 1xxx the priority result.
// - Priority hardware start source is the external trigger at 0, timer match at 1.
// - Priority hardware starts pass only while the priority hardware enable is set.
// - Normal hardware start source is the external trigger at 0, timer match at 1.
// - Normal hardware starts pass only while the normal hardware enable is set.
// - Writing key 10 then key 01 to the reset field performs a converter soft reset.
// - The soft reset clears every register except the clock divider setting.
// - Each result register holds its 10-bit result in bits 15 down to 6.
// - Monitor 0 events also raise a DMA request when its DMA enable is set.
module amtc_top #(
   parameter int NUM_NORMAL = 8,
   parameter int DIV_WIDTH = 3
) (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic [7:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [7:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   input wire logic i_ext_trigger,
   input wire logic i_timer_match,
   input wire logic i_result_valid,
   input wire logic [3:0] i_result_index,
   input wire logic [9:0] i_result_value,
   output logic o_normal_hw_start,
   output logic o_priority_hw_start,
   output logic o_mon0_irq,
   output logic o_mon1_irq,
   output logic o_mon0_dma_req,
   output logic o_mon1_dma_req,
   output logic o_irq,
   output logic o_soft_reset,
   output logic [DIV_WIDTH-1:0] o_converter_clock_divider
);
   amtc_pkg::amtc_mon_cfg_t monitor_zero_setup;
   amtc_pkg::amtc_mon_cfg_t monitor_one_setup;
   logic [3:0] hw_trigger_and_soft_reset;
   logic [9:0] cmp0;
   logic [9:0] cmp1;
   logic [1:0] dma_en;
   logic [DIV_WIDTH-1:0] converter_clock_divider;
   logic [1:0] irq_stat;
   logic [1:0] irq_mask;
   logic [9:0] normal_result_reg [NUM_NORMAL];
   logic [9:0] priority_result_reg;
   amtc_pkg::amtc_key_state_t key_state;
   logic soft_rst;
   logic ext_s1, ext_s2, tmr_s1, tmr_s2;
   logic aw_held, w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic do_write;
   logic mon0_event, mon1_event;
   amtc_pkg::amtc_result_t store;
   logic [31:0] next_rdata;
   logic next_rresp_err;
   logic wr_ok;

   // Trigger pins come from outside the clock domain
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         ext_s1 <= 1'b0;
         ext_s2 <= 1'b0;
         tmr_s1 <= 1'b0;
         tmr_s2 <= 1'b0;
      end else begin
         ext_s1 <= i_ext_trigger;
         ext_s2 <= ext_s1;
         tmr_s1 <= i_timer_match;
         tmr_s2 <= tmr_s1;
      end
   end

   // Write address and data held until both have arrived
   assign o_awready = !aw_held && !o_bvalid;
   assign o_wready = !w_held && !o_bvalid;
   assign do_write = aw_held && w_held && !o_bvalid;

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else begin
         if (i_awvalid && o_awready) begin
            aw_held <= 1'b1;
            aw_addr <= i_awaddr;
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
         if (i_wvalid && o_wready) begin
            w_held <= 1'b1;
            w_data <= i_wdata;
            w_strb <= i_wstrb;
         end else if (do_write) begin
            w_held <= 1'b0;
         end
      end
   end

   // Mapped write offsets answer OKAY, others SLVERR
   always_comb begin
      if (aw_addr == `AMTC_OFF_MON0 || aw_addr == `AMTC_OFF_HWTRIG || aw_addr == `AMTC_OFF_MON1) begin
         wr_ok = 1'b1;
      end else if (aw_addr == `AMTC_OFF_CMP0 || aw_addr == `AMTC_OFF_CMP1 || aw_addr == `AMTC_OFF_DMAEN) begin
         wr_ok = 1'b1;
      end else if (aw_addr == `AMTC_OFF_DIVIDER || aw_addr == `AMTC_OFF_IRQ_STAT) begin
         wr_ok = 1'b1;
      end else if (aw_addr == `AMTC_OFF_IRQ_MASK) begin
         wr_ok = 1'b1;
      end else begin
         wr_ok = 1'b0;
      end
   end

   // Write response
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_bvalid <= 1'b0;
         o_bresp <= 2'h0;
      end else if (do_write) begin
         o_bvalid <= 1'b1;
         o_bresp <= wr_ok ? 2'h0 : 2'h2;
      end else if (o_bvalid && i_bready) begin
         o_bvalid <= 1'b0;
      end
   end

   // Key sequence: 10 arms, 01 as the next key write fires; any other key value disarms, 10 keeps it armed
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         key_state <= amtc_pkg::AMTC_KEY_IDLE;
         soft_rst <= 1'b0;
      end else begin
         soft_rst <= 1'b0;
         if (do_write && aw_addr == `AMTC_OFF_HWTRIG && w_strb[0]) begin
            case (key_state)
               amtc_pkg::AMTC_KEY_IDLE: begin
                  if (w_data[`AMTC_KEY_MSB:`AMTC_KEY_LSB] == `AMTC_KEY_FIRST) begin
                     key_state <= amtc_pkg::AMTC_KEY_ARMED;
                  end
               end
               amtc_pkg::AMTC_KEY_ARMED: begin
                  if (w_data[`AMTC_KEY_MSB:`AMTC_KEY_LSB] == `AMTC_KEY_SECOND) begin
                     soft_rst <= 1'b1;
                     key_state <= amtc_pkg::AMTC_KEY_IDLE;
                  end else if (w_data[`AMTC_KEY_MSB:`AMTC_KEY_LSB] != `AMTC_KEY_FIRST) begin
                     key_state <= amtc_pkg::AMTC_KEY_IDLE;
                  end
               end
               default: begin
                  key_state <= amtc_pkg::AMTC_KEY_IDLE;
               end
            endcase
         end
      end
   end
   assign o_soft_reset = soft_rst;

   // Configuration registers; soft reset clears all but the divider
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         monitor_zero_setup <= '0;
         monitor_one_setup <= '0;
         hw_trigger_and_soft_reset <= 4'h0;
         cmp0 <= 10'h000;
         cmp1 <= 10'h000;
         dma_en <= 2'h0;
         irq_mask <= 2'h0;
      end else if (soft_rst) begin
         monitor_zero_setup <= '0;
         monitor_one_setup <= '0;
         hw_trigger_and_soft_reset <= 4'h0;
         cmp0 <= 10'h000;
         cmp1 <= 10'h000;
         dma_en <= 2'h0;
         irq_mask <= 2'h0;
      end else if (do_write && w_strb[0]) begin
         if (aw_addr == `AMTC_OFF_MON0) begin
            monitor_zero_setup <= w_data[`AMTC_MON_DIR_BIT:`AMTC_MON_ENABLE_BIT];
         end else if (aw_addr == `AMTC_OFF_MON1) begin
            monitor_one_setup <= w_data[`AMTC_MON_DIR_BIT:`AMTC_MON_ENABLE_BIT];
         end else if (aw_addr == `AMTC_OFF_HWTRIG) begin
            hw_trigger_and_soft_reset <= w_data[`AMTC_HW_PRIO_SRC_BIT:`AMTC_HW_NORM_EN_BIT];
         end else if (aw_addr == `AMTC_OFF_DMAEN) begin
            dma_en <= w_data[1:0];
         end else if (aw_addr == `AMTC_OFF_IRQ_MASK) begin
            irq_mask <= w_data[1:0];
         end else if (aw_addr == `AMTC_OFF_CMP0) begin
            cmp0 <= w_strb[1] ? w_data[9:0] : {cmp0[9:8], w_data[7:0]};
         end else if (aw_addr == `AMTC_OFF_CMP1) begin
            cmp1 <= w_strb[1] ? w_data[9:0] : {cmp1[9:8], w_data[7:0]};
         end
      end
   end

   // Divider survives the soft reset on purpose
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         converter_clock_divider <= '0;
      end else if (do_write && w_strb[0] && aw_addr == `AMTC_OFF_DIVIDER) begin
         converter_clock_divider <= w_data[DIV_WIDTH-1:0];
      end
   end
   assign o_converter_clock_divider = converter_clock_divider;

   // Result capture from the converter core, stored left-justified on read
   assign store = '{valid: i_result_valid, index: i_result_index, value: i_result_value};

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         for (int k = 0; k < NUM_NORMAL; k++) begin
            normal_result_reg[k] <= 10'h000;
         end
         priority_result_reg <= 10'h000;
      end else if (soft_rst) begin
         for (int k = 0; k < NUM_NORMAL; k++) begin
            normal_result_reg[k] <= 10'h000;
         end
         priority_result_reg <= 10'h000;
      end else if (i_result_valid) begin
         if (i_result_index[3]) begin
            priority_result_reg <= i_result_value;
         end else if (32'(i_result_index) < NUM_NORMAL) begin
            normal_result_reg[i_result_index[2:0]] <= i_result_value;
         end
      end
   end

   amtc_monitor u_mon0 (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_soft_rst(soft_rst),
      .i_cfg(monitor_zero_setup),
      .i_compare(cmp0),
      .i_store(store),
      .o_event(mon0_event)
   );

   amtc_monitor u_mon1 (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_soft_rst(soft_rst),
      .i_cfg(monitor_one_setup),
      .i_compare(cmp1),
      .i_store(store),
      .o_event(mon1_event)
   );

   assign o_mon0_irq = mon0_event;
   assign o_mon1_irq = mon1_event;
   assign o_mon0_dma_req = mon0_event && dma_en[0];
   assign o_mon1_dma_req = mon1_event && dma_en[1];

   // Sticky status; a new event beats a write-one clear
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         irq_stat <= 2'h0;
      end else if (soft_rst) begin
         irq_stat <= 2'h0;
      end else begin
         for (int k = 0; k < 2; k++) begin
            if ((k == 0) ? mon0_event : mon1_event) begin
               irq_stat[k] <= 1'b1;
            end else if (do_write && w_strb[0] && aw_addr == `AMTC_OFF_IRQ_STAT && w_data[k]) begin
               irq_stat[k] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(irq_stat & irq_mask);
      end
   end

   // Hardware start gating; conflicts are software's to avoid
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_normal_hw_start <= 1'b0;
         o_priority_hw_start <= 1'b0;
      end else begin
         o_priority_hw_start <= hw_trigger_and_soft_reset[`AMTC_HW_PRIO_EN_BIT-`AMTC_HW_NORM_EN_BIT] &&
            (hw_trigger_and_soft_reset[`AMTC_HW_PRIO_SRC_BIT-`AMTC_HW_NORM_EN_BIT] ? tmr_s2 : ext_s2);
         o_normal_hw_start <= hw_trigger_and_soft_reset[0] &&
            (hw_trigger_and_soft_reset[`AMTC_HW_NORM_SRC_BIT-`AMTC_HW_NORM_EN_BIT] ? tmr_s2 : ext_s2);
      end
   end

   // Read mux; key field is write-only and reads zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      next_rresp_err = 1'b0;
      if (i_araddr == `AMTC_OFF_MON0) begin
         next_rdata[`AMTC_MON_DIR_BIT:`AMTC_MON_ENABLE_BIT] = monitor_zero_setup;
      end else if (i_araddr == `AMTC_OFF_HWTRIG) begin
         next_rdata[`AMTC_HW_PRIO_SRC_BIT:`AMTC_HW_NORM_EN_BIT] = hw_trigger_and_soft_reset;
      end else if (i_araddr == `AMTC_OFF_MON1) begin
         next_rdata[`AMTC_MON_DIR_BIT:`AMTC_MON_ENABLE_BIT] = monitor_one_setup;
      end else if (i_araddr == `AMTC_OFF_CMP0) begin
         next_rdata[9:0] = cmp0;
      end else if (i_araddr == `AMTC_OFF_CMP1) begin
         next_rdata[9:0] = cmp1;
      end else if (i_araddr == `AMTC_OFF_DMAEN) begin
         next_rdata[1:0] = dma_en;
      end else if (i_araddr == `AMTC_OFF_DIVIDER) begin
         next_rdata[DIV_WIDTH-1:0] = converter_clock_divider;
      end else if (i_araddr == `AMTC_OFF_IRQ_STAT) begin
         next_rdata[1:0] = irq_stat;
      end else if (i_araddr == `AMTC_OFF_IRQ_MASK) begin
         next_rdata[1:0] = irq_mask;
      end else if (i_araddr == `AMTC_OFF_RES_PRIO) begin
         next_rdata[`AMTC_RES_MSB:`AMTC_RES_LSB] = priority_result_reg;
      end else if (i_araddr >= `AMTC_OFF_RES_BASE && i_araddr < `AMTC_OFF_RES_PRIO && i_araddr[1:0] == 2'h0
                   && 32'(i_araddr[4:2]) < NUM_NORMAL) begin
         next_rdata[`AMTC_RES_MSB:`AMTC_RES_LSB] = normal_result_reg[i_araddr[4:2]];
      end else begin
         next_rresp_err = 1'b1;
      end
   end

   assign o_arready = !o_rvalid;

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rvalid <= 1'b0;
         o_rdata <= 32'h0000_0000;
         o_rresp <= 2'h0;
      end else if (i_arvalid && o_arready) begin
         o_rvalid <= 1'b1;
         o_rdata <= next_rdata;
         o_rresp <= next_rresp_err ? 2'h2 : 2'h0;
      end else if (o_rvalid && i_rready) begin
         o_rvalid <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ---- hdl/amtc_params.svh ----
// Register offsets, field positions and reset values for the monitor/trigger control block
`ifndef AMTC_PARAMS_SVH
`define AMTC_PARAMS_SVH
`define AMTC_OFF_MON0 8'h00
`define AMTC_OFF_HWTRIG 8'h04
`define AMTC_OFF_MON1 8'h08
`define AMTC_OFF_CMP0 8'h0C
`define AMTC_OFF_CMP1 8'h10
`define AMTC_OFF_DMAEN 8'h14
`define AMTC_OFF_DIVIDER 8'h18
`define AMTC_OFF_IRQ_STAT 8'h1C
`define AMTC_OFF_IRQ_MASK 8'h20
`define AMTC_OFF_RES_BASE 8'h40
`define AMTC_OFF_RES_PRIO 8'h60
`define AMTC_MON_ENABLE_BIT 0
`define AMTC_MON_SEL_LSB 1
`define AMTC_MON_SEL_MSB 4
`define AMTC_MON_DIR_BIT 5
`define AMTC_MON_WMASK 8'h3F
`define AMTC_HW_NORM_EN_BIT 4
`define AMTC_HW_NORM_SRC_BIT 5
`define AMTC_HW_PRIO_EN_BIT 6
`define AMTC_HW_PRIO_SRC_BIT 7
`define AMTC_HW_WMASK 8'hF0
`define AMTC_KEY_LSB 0
`define AMTC_KEY_MSB 1
`define AMTC_KEY_FIRST 2'h2
`define AMTC_KEY_SECOND 2'h1
`define AMTC_RES_LSB 6
`define AMTC_RES_MSB 15
`define AMTC_REG_RESET 8'h00
`endif

// ---- hdl/amtc_pkg.sv ----
// Types shared by the monitor/trigger control block
package amtc_pkg;
   typedef struct packed {
      logic direction;
      logic [3:0] result_select;
      logic enable;
   } amtc_mon_cfg_t;

   typedef struct packed {
      logic valid;
      logic [3:0] index;
      logic [9:0] value;
   } amtc_result_t;

   typedef enum logic [1:0] {
      AMTC_KEY_IDLE,
      AMTC_KEY_ARMED
   } amtc_key_state_t;
endpackage

// ---- hdl/amtc_monitor.sv ----
// One single-threshold compare monitor that watches a selected result register
`timescale 1ns/1ps
`default_nettype none
module amtc_monitor (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_soft_rst,
   input wire amtc_pkg::amtc_mon_cfg_t i_cfg,
   input wire logic [9:0] i_compare,
   input wire amtc_pkg::amtc_result_t i_store,
   output logic o_event
);
   logic target_hit;
   logic cond;

   // Codes 1xxx watch the priority register, which every store index 1xxx lands in
   always_comb begin
      if (i_cfg.result_select[3]) begin
         target_hit = i_store.index[3];
      end else begin
         target_hit = (i_store.index == i_cfg.result_select);
      end
   end

   // Direction picks below or above; equal never fires
   assign cond = i_cfg.direction ? (i_store.value > i_compare) : (i_store.value < i_compare);

   // Evaluate only on a fresh store into the watched register
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_event <= 1'b0;
      end else if (i_soft_rst) begin
         o_event <= 1'b0;
      end else begin
         o_event <= i_cfg.enable && i_store.valid && target_hit && cond;
      end
   end
endmodule
`default_nettype wire

// ---- tb/amtc_chk.sv ----
// Port-level assertion checker for the monitor/trigger control block
`timescale 1ns/1ps
`default_nettype none
module amtc_chk (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_bready,
   input wire logic i_rready,
   input wire logic o_bvalid,
   input wire logic o_rvalid,
   input wire logic o_arready,
   input wire logic i_arvalid,
   input wire logic i_result_valid,
   input wire logic o_mon0_irq,
   input wire logic o_mon1_irq,
   input wire logic o_mon0_dma_req,
   input wire logic o_mon1_dma_req,
   input wire logic o_soft_reset,
   input wire logic o_irq,
   input wire logic i_ext_trigger,
   input wire logic i_timer_match,
   input wire logic o_normal_hw_start,
   input wire logic o_priority_hw_start
);
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_rst);
   // Both start inputs idle long enough to flush the two-flop synchronisers
   sequence s_inputs_quiet;
      (!i_ext_trigger && !i_timer_match) [*5];
   endsequence
   // Soft reset pulse seen
   sequence s_soft_pulse;
      o_soft_reset;
   endsequence
   a_mon0_from_store: assert property (o_mon0_irq |-> $past(i_result_valid))
      else $error("monitor 0 pulse without a stored result");
   a_mon1_from_store: assert property (o_mon1_irq |-> $past(i_result_valid))
      else $error("monitor 1 pulse without a stored result");
   a_dma0_gated: assert property (o_mon0_dma_req |-> o_mon0_irq)
      else $error("monitor 0 dma request without its event");
   a_dma1_gated: assert property (o_mon1_dma_req |-> o_mon1_irq)
      else $error("monitor 1 dma request without its event");
   a_start_idle: assert property (s_inputs_quiet |-> !o_normal_hw_start && !o_priority_hw_start)
      else $error("hardware start with both sources idle");
   a_soft_single: assert property (s_soft_pulse |=> !o_soft_reset)
      else $error("soft reset pulse longer than one cycle");
   a_soft_after_write: assert property (s_soft_pulse |-> o_bvalid)
      else $error("soft reset pulse not following a write");
   a_soft_clears_all: assert property (s_soft_pulse |-> ##3 (!o_irq && !o_normal_hw_start && !o_priority_hw_start))
      else $error("outputs still active after soft reset");
   // Bus handshakes release once taken; an accepted read is answered next cycle
   a_bresp_once: assert property (o_bvalid && i_bready |=> !o_bvalid)
      else $error("write response repeated");
   a_rdata_once: assert property (o_rvalid && i_rready |=> !o_rvalid)
      else $error("read response repeated");
   a_read_ready: assert property (i_arvalid && o_arready |=> o_rvalid)
      else $error("accepted read address not answered next cycle");
endmodule

bind amtc_top amtc_chk u_chk (
   .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_bready(i_bready), .i_rready(i_rready), .o_bvalid(o_bvalid),
   .o_rvalid(o_rvalid), .o_arready(o_arready), .i_arvalid(i_arvalid), .i_result_valid(i_result_valid),
   .o_mon0_irq(o_mon0_irq),
   .o_mon1_irq(o_mon1_irq), .o_mon0_dma_req(o_mon0_dma_req), .o_mon1_dma_req(o_mon1_dma_req),
   .o_soft_reset(o_soft_reset), .o_irq(o_irq), .i_ext_trigger(i_ext_trigger), .i_timer_match(i_timer_match),
   .o_normal_hw_start(o_normal_hw_start), .o_priority_hw_start(o_priority_hw_start)
);
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the monitor/trigger control block
`timescale 1ns/1ps
`default_nettype none
`include "amtc_params.svh"
module tb;
   logic clk, rst, awvalid, wvalid, bready, arvalid, rready, ext, tim, rv;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, seed, d;
   logic [3:0] wstrb, ridx, x;
   logic [9:0] rval, k0, k1, v;
   logic awrdy, wrdy, bvalid, arrdy, rvalid, nstart, pstart, irq0, irq1, dma0, dma1, irq, srst, h0, h1;
   logic [1:0] bresp, rresp, r, stat, dm, mk;
   logic [2:0] div;
   logic [5:0] c0, c1;
   int errors, comparisons;
   int pulses = 0;

   amtc_top DUT (
      .i_sys_clk(clk), .i_rst(rst), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awrdy),
      .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wrdy), .o_bresp(bresp),
      .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arrdy),
      .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .i_ext_trigger(ext),
      .i_timer_match(tim), .i_result_valid(rv), .i_result_index(ridx), .i_result_value(rval),
      .o_normal_hw_start(nstart), .o_priority_hw_start(pstart), .o_mon0_irq(irq0), .o_mon1_irq(irq1),
      .o_mon0_dma_req(dma0), .o_mon1_dma_req(dma1), .o_irq(irq), .o_soft_reset(srst),
      .o_converter_clock_divider(div)
   );

   // Free-running system clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Soft reset pulses counted for the key sequence checks
   always @(posedge clk) begin
      if (srst === 1'b1) pulses++;
   end

   function automatic logic [31:0] xs;
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Expected monitor event: enabled, watching this register, strictly past the limit
   function automatic logic hit(input logic [5:0] c, input logic [9:0] k, input logic [3:0] i, input logic [9:0] val);
      logic same;
      same = c[4] ? i[3] : (i == c[4:1]);
      return c[0] && same && (c[5] ? val > k : val < k);
   endfunction

   task automatic print_verdict;
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // A bound that runs out ends the run as a mismatch
   task automatic bound(input int n);
      if (n >= 50) begin
         errors++;
         print_verdict();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] resp);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= dat;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (awvalid && awrdy) awvalid <= 1'b0;
         if (wvalid && wrdy) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 50);
      resp = bresp;
      bound(n);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] resp);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (arvalid && arrdy) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 50);
      dat = rdata;
      resp = rresp;
      bound(n);
   endtask

   initial begin
      rst = 1'b1;
      {awvalid, wvalid, arvalid, ext, tim, rv, awaddr, araddr, wdata, ridx, rval} = '0;
      // Responses always accepted at once; every byte lane written
      bready = 1'b1;
      rready = 1'b1;
      wstrb = 4'hF;
      errors = 0;
      comparisons = 0;
      stat = 2'h0;
      seed = 32'h0000F9B8;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // Reset values of the three mode registers
      for (int i = 0; i < 3; i++) begin
         rd(8'(4 * i), d, r);
         chk(d, 36'h0);
      end
      // Writable fields and read-as-zero bits
      wr(`AMTC_OFF_MON0, 32'hFFFFFFFF, r);
      chk(r, 36'h0);
      rd(`AMTC_OFF_MON0, d, r);
      chk(d, 36'h3F);
      wr(`AMTC_OFF_MON1, 32'hFFFFFFFF, r);
      rd(`AMTC_OFF_MON1, d, r);
      chk(d, 36'h3F);
      wr(`AMTC_OFF_HWTRIG, 32'h000000FC, r);
      rd(`AMTC_OFF_HWTRIG, d, r);
      chk(d, 36'hF0);
      // Unmapped place answers with a slave error
      wr(8'h3C, 32'hFFFFFFFF, r);
      chk(r, 36'h2);
      rd(8'h3C, d, r);
      chk({r, d}, {2'h2, 32'h0});
      // Random monitor traffic with equal-value and matching-index corners
      for (int i = 0; i < 240; i++) begin
         if (i % 16 == 0) begin
            d = xs();
            {c0, c1, dm, mk, k0} = d[25:0];
            d = xs();
            k1 = d[9:0];
            wr(`AMTC_OFF_MON0, {26'h0, c0}, r);
            wr(`AMTC_OFF_MON1, {26'h0, c1}, r);
            wr(`AMTC_OFF_CMP0, {22'h0, k0}, r);
            wr(`AMTC_OFF_CMP1, {22'h0, k1}, r);
            wr(`AMTC_OFF_DMAEN, {30'h0, dm}, r);
            wr(`AMTC_OFF_IRQ_MASK, {30'h0, mk}, r);
            rd(`AMTC_OFF_IRQ_STAT, d, r);
            chk(d, {34'h0, stat});
            wr(`AMTC_OFF_IRQ_STAT, 32'h3, r);
            stat = 2'h0;
         end
         d = xs();
         x = d[0] ? (d[3] ? c1[4:1] : c0[4:1]) : d[7:4];
         v = d[1] ? (d[2] ? k0 : k1) : d[17:8];
         h0 = hit(c0, k0, x, v);
         h1 = hit(c1, k1, x, v);
         stat = stat | {h1, h0};
         ridx <= x;
         rval <= v;
         rv <= 1'b1;
         @(posedge clk);
         rv <= 1'b0;
         @(posedge clk);
         chk({irq1, irq0, dma1, dma0}, {h1, h0, h1 & dm[1], h0 & dm[0]});
         // Status sets one edge after the pulse, the level one edge later
         repeat (2) @(posedge clk);
         chk(irq, |(stat & mk));
         rd(x[3] ? `AMTC_OFF_RES_PRIO : `AMTC_OFF_RES_BASE + {2'b00, x, 2'b00}, d, r);
         chk(d & 32'hFFFFFFC0, {16'h0, v, 6'h0});
      end
      // Every enable and source combination except both enabled on the external trigger, against both start inputs
      for (int k = 0; k < 16; k++) begin
         if (k[0] && !k[1] && k[2] && !k[3]) continue;
         wr(`AMTC_OFF_HWTRIG, {24'h0, k[3:0], 4'h0}, r);
         for (int t = 0; t < 4; t++) begin
            ext <= t[0];
            tim <= t[1];
            repeat (6) @(posedge clk);
            chk({pstart, nstart}, {k[2] & (k[3] ? t[1] : t[0]), k[0] & (k[1] ? t[1] : t[0])});
         end
      end
      ext <= 1'b0;
      tim <= 1'b0;
      // A wrong second key disarms the sequence
      wr(`AMTC_OFF_DIVIDER, 32'h5, r);
      wr(`AMTC_OFF_HWTRIG, 32'h2, r);
      wr(`AMTC_OFF_HWTRIG, 32'h3, r);
      wr(`AMTC_OFF_HWTRIG, 32'h1, r);
      repeat (4) @(posedge clk);
      chk(pulses, 36'h0);
      // Right pair, with another register written in between
      wr(`AMTC_OFF_HWTRIG, 32'h2, r);
      wr(`AMTC_OFF_MON1, 32'h3F, r);
      wr(`AMTC_OFF_HWTRIG, 32'h1, r);
      repeat (4) @(posedge clk);
      chk(pulses, 36'h1);
      for (int i = 0; i < 10; i++) begin
         rd(8'(4 * i), d, r);
         chk(d, (i == 6) ? 36'h5 : 36'h0);
      end
      rd(`AMTC_OFF_RES_PRIO, d, r);
      chk(d, 36'h0);
      chk(div, 36'h5);
      print_verdict();
   end
endmodule
`default_nettype wire
